/* link_sync_pkg.sv */
// link_sync_pkg: constants and types for the link sync request controller
// assumes a single core clock domain at 10 MHz
package link_sync_pkg;

    localparam int unsigned SYNC_STAGES      = 3;
    localparam logic [1:0]  SYNC_SEL_SE      = 2'h0;
    localparam logic [1:0]  SYNC_SEL_TS      = 2'h1;
    localparam logic [1:0]  SYNC_SEL_ALT     = 2'h2;
    localparam logic [7:0]  COMMA_K28_5      = 8'hbc;
    localparam logic [7:0]  ILAS_START_K28_0 = 8'h1c;
    localparam logic [7:0]  IDLE_DATA        = 8'h00;
    localparam int unsigned LANES_DEFAULT    = 8;
    localparam int unsigned ILAS_LEN_DEFAULT = 4;

    typedef enum logic {
        ENC_8B10B,
        ENC_64B66B
    } encoding_type;

    typedef enum {
        ST_IDLE,
        ST_CGS,
        ST_ILAS,
        ST_DATA
    } link_state_type;

endpackage : link_sync_pkg

/* pin_sync.sv */
// pin_sync: three-flop synchroniser with agreement filter for one pin
// assumes the input is asynchronous to i_core_clk
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    // pin and filtered level
    input  wire logic i_pin,
    output logic      o_level
);
    typedef struct packed {
        logic [2:0] stage;
        logic       level;
    } sync_state_type;

    sync_state_type state;
    sync_state_type next_state;

    always_comb begin
        next_state       = state;
        next_state.stage = {state.stage[1:0], i_pin};
        // change only when second and third flops agree
        if (state.stage[1] == state.stage[2]) begin
            next_state.level = state.stage[2];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state <= '{stage: {3{RESET_LEVEL}}, level: RESET_LEVEL};
        end else begin
            state <= next_state;
        end
    end

    assign o_level = state.level;

endmodule : pin_sync

/* serial_link_sync_request_control.sv */
// serial_link_sync_request_control: link sync request and lane bring-up sequencing
// assumes pins are asynchronous; control inputs come from same-clock configuration logic
//
// Operation
// - low single-ended request starts link init only in 8B/10B with select 0.
// - in 64B/66B the request line is ignored; link comes up unaided.
// - request going low in 8B/10B starts code group synchronization.
// - SYSREF edge is the alignment reference for deterministic latency.
// - SYSREF receiver can be powered down by its receiver enable.
// - differential timestamp input may serve as alternative request in 8B/10B.
`timescale 1ns/100ps
module serial_link_sync_request_control
    import link_sync_pkg::*;
#(
    parameter int unsigned LANES    = link_sync_pkg::LANES_DEFAULT,
    parameter int unsigned ILAS_LEN = link_sync_pkg::ILAS_LEN_DEFAULT
) (
    // clock and reset
    input  wire logic                        i_core_clk,
    input  wire logic                        i_sys_rst,
    // configuration
    input  wire link_sync_pkg::encoding_type i_encoding,
    input  wire logic [1:0]                  i_sync_sel,
    input  wire logic [LANES-1:0]            i_lane_enable,
    input  wire logic                        i_link_enable,
    input  wire logic                        i_sysref_receiver_power_enable,
    // pins
    input  wire logic                        i_single_ended_link_request_n,
    input  wire logic                        i_timestamp_diff_input,
    input  wire logic                        i_alternate_link_request_n,
    input  wire logic                        i_sysref,
    // lane character output
    output logic [LANES*8-1:0]               o_lane_char,
    output logic [LANES-1:0]                 o_lane_char_is_k,
    // status
    output logic                             o_sysref_receiver_on,
    output logic                             o_sysref_edge,
    output logic                             o_in_cgs,
    output logic                             o_in_ilas,
    output logic                             o_link_up
);
    import link_sync_pkg::*;

    typedef struct packed {
        link_state_type    mode;
        logic [7:0]        ilas_cnt;
        logic              req_prev;
        logic              sysref_prev;
        logic              sysref_edge;
        logic              sysref_rx_on;
        logic [LANES*8-1:0] lane_char;
        logic [LANES-1:0]  lane_is_k;
        logic              in_cgs;
        logic              in_ilas;
        logic              link_up;
    } ctrl_state_type;

    ctrl_state_type state;
    ctrl_state_type next_state;

    logic se_req_n;
    logic ts_req_n;
    logic alt_req_n;
    logic sysref_lvl;

    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_se (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_pin      (i_single_ended_link_request_n),
        .o_level    (se_req_n)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_ts (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_pin      (i_timestamp_diff_input),
        .o_level    (ts_req_n)
    );

    pin_sync #(.RESET_LEVEL(1'b1)) u_sync_alt (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_pin      (i_alternate_link_request_n),
        .o_level    (alt_req_n)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) u_sync_sysref (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_pin      (i_sysref & i_sysref_receiver_power_enable),
        .o_level    (sysref_lvl)
    );

    logic req_n;
    logic req_fall;
    logic req_rise;
    logic is_8b10b;

    always_comb begin
        is_8b10b = (i_encoding == ENC_8B10B);
        // source select; unused sources read as released
        unique case (i_sync_sel)
            SYNC_SEL_SE:    req_n = se_req_n;
            SYNC_SEL_TS:    req_n = ts_req_n;
            SYNC_SEL_ALT:   req_n = alt_req_n;
            default:        req_n = 1'b1;
        endcase
        if (!is_8b10b) begin
            req_n = 1'b1;
        end
        req_fall = state.req_prev & ~req_n;
        req_rise = ~state.req_prev & req_n;
    end

    always_comb begin
        next_state              = state;
        next_state.req_prev     = req_n;
        next_state.sysref_rx_on = i_sysref_receiver_power_enable;
        next_state.sysref_prev  = sysref_lvl;
        next_state.sysref_edge  = sysref_lvl & ~state.sysref_prev;

        if (!i_link_enable) begin
            next_state.mode = ST_IDLE;
        end else begin
            unique case (state.mode)
                ST_IDLE: begin
                    if (!is_8b10b) begin
                        next_state.mode = ST_DATA;
                    end else if (req_fall || !req_n) begin
                        next_state.mode = ST_CGS;
                    end
                end
                ST_CGS: begin
                    if (!is_8b10b) begin
                        next_state.mode = ST_DATA;
                    end else if (req_rise) begin
                        next_state.mode     = ST_ILAS;
                        next_state.ilas_cnt = 8'h00;
                    end
                end
                ST_ILAS: begin
                    if (!is_8b10b) begin
                        next_state.mode = ST_DATA;
                    end else if (!req_n) begin
                        next_state.mode = ST_CGS;
                    end else if (state.sysref_edge || state.ilas_cnt != 8'h00) begin
                        // ilas multiframes counted from the sysref reference
                        if (state.ilas_cnt == 8'(ILAS_LEN - 1)) begin
                            next_state.mode = ST_DATA;
                        end else begin
                            next_state.ilas_cnt = state.ilas_cnt + 8'h01;
                        end
                    end
                end
                ST_DATA: begin
                    if (is_8b10b && req_fall) begin
                        next_state.mode = ST_CGS;
                    end
                end
            endcase
        end

        // lane characters follow the mode being entered
        for (int i = 0; i < LANES; i++) begin
            next_state.lane_char[i*8 +: 8] = IDLE_DATA;
            next_state.lane_is_k[i]        = 1'b0;
            if (i_lane_enable[i]) begin
                unique case (next_state.mode)
                    ST_CGS: begin
                        next_state.lane_char[i*8 +: 8] = COMMA_K28_5;
                        next_state.lane_is_k[i]        = 1'b1;
                    end
                    ST_ILAS: begin
                        next_state.lane_char[i*8 +: 8] = ILAS_START_K28_0;
                        next_state.lane_is_k[i]        = 1'b1;
                    end
                    ST_IDLE,
                    ST_DATA: begin
                        next_state.lane_char[i*8 +: 8] = IDLE_DATA;
                        next_state.lane_is_k[i]        = 1'b0;
                    end
                endcase
            end
        end
        next_state.in_cgs  = (next_state.mode == ST_CGS);
        next_state.in_ilas = (next_state.mode == ST_ILAS);
        next_state.link_up = (next_state.mode == ST_DATA);
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state          <= '0;
            state.mode     <= ST_IDLE;
            state.req_prev <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign o_lane_char          = state.lane_char;
    assign o_lane_char_is_k     = state.lane_is_k;
    assign o_sysref_receiver_on = state.sysref_rx_on;
    assign o_sysref_edge        = state.sysref_edge;
    assign o_in_cgs             = state.in_cgs;
    assign o_in_ilas            = state.in_ilas;
    assign o_link_up            = state.link_up;

endmodule : serial_link_sync_request_control

/* link_sync_asserts.sv */
// link_sync_asserts: port assertions for the link sync request controller
// assumes it is bound into serial_link_sync_request_control
`timescale 1ns/100ps
module link_sync_asserts
    import link_sync_pkg::*;
#(
    parameter int unsigned LANES = 8
) (
    input wire logic                        i_core_clk,
    input wire logic                        i_sys_rst,
    input wire link_sync_pkg::encoding_type i_encoding,
    input wire logic [1:0]                  i_sync_sel,
    input wire logic                        i_link_enable,
    input wire logic                        i_sysref_receiver_power_enable,
    input wire logic                        i_single_ended_link_request_n,
    input wire logic                        i_alternate_link_request_n,
    input wire logic [LANES*8-1:0]          o_lane_char,
    input wire logic                        o_sysref_edge,
    input wire logic                        o_in_cgs,
    input wire logic                        o_in_ilas,
    input wire logic                        o_link_up
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    wire logic m8 = (i_encoding == ENC_8B10B) && i_link_enable;

    se_start_a: assert property ((m8 && i_sync_sel == SYNC_SEL_SE && !i_single_ended_link_request_n) [*8]
        |-> o_in_cgs) else $error("low request did not start sync");
    se_gate_a: assert property ((m8 && i_sync_sel == SYNC_SEL_ALT && i_alternate_link_request_n) [*8]
        |-> !o_in_cgs) else $error("unselected request started sync");
    wide_ignore_a: assert property ((i_encoding == ENC_64B66B) [*3] |-> !o_in_cgs && !o_in_ilas)
        else $error("request used in wide mode");
    wide_up_a: assert property (i_encoding == ENC_64B66B && i_link_enable && !o_in_cgs && !o_in_ilas
        && !o_link_up |=> o_link_up) else $error("wide mode link not up");
    comma_a: assert property (o_in_cgs |-> o_lane_char[7:0] == COMMA_K28_5)
        else $error("no comma during sync");
    ilas_order_a: assert property ($rose(o_in_ilas) |-> $past(o_in_cgs))
        else $error("alignment without sync");
    ilas_char_a: assert property (o_in_ilas |-> o_lane_char[7:0] == ILAS_START_K28_0)
        else $error("wrong alignment char");
    up_order_a: assert property ($rose(o_link_up) && $past(m8) |-> $past(o_in_ilas))
        else $error("link up without alignment");
    sysref_off_a: assert property (!i_sysref_receiver_power_enable [*6] |-> !o_sysref_edge)
        else $error("edge from unpowered receiver");

    cover property ($rose(o_in_cgs));
    cover property ($rose(o_link_up));
    cover property (o_sysref_edge);
endmodule : link_sync_asserts

bind serial_link_sync_request_control link_sync_asserts #(.LANES(LANES)) chk (.i_core_clk, .i_sys_rst,
    .i_encoding, .i_sync_sel, .i_link_enable, .i_sysref_receiver_power_enable, .i_single_ended_link_request_n,
    .i_alternate_link_request_n, .o_lane_char, .o_sysref_edge, .o_in_cgs, .o_in_ilas, .o_link_up);

/* link_rx_model.sv */
// link_rx_model: receiver logic driving the single-ended request
// assumes it shares the core clock
`timescale 1ns/100ps
module link_rx_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_start,
    input  wire logic [3:0] i_hold,
    input  wire logic       i_in_cgs,
    output logic            o_request_n
);
    logic [3:0] seen;
    initial begin
        o_request_n = 1'b1;
        seen = 4'h0;
    end
    always @(posedge i_core_clk) begin
        seen <= i_in_cgs ? seen + 4'h1 : 4'h0;
        if (i_start) begin
            o_request_n <= #10 1'b0;
        end else if (seen >= i_hold) begin
            o_request_n <= #10 1'b1;
        end
    end
endmodule : link_rx_model

/* serial_link_sync_request_control_tb.sv */
// serial_link_sync_request_control_tb: scenario bench for the request controller
// assumes default lane count and alignment length
`timescale 1ns/100ps
module serial_link_sync_request_control_tb;
    import link_sync_pkg::*;
    logic         clk, rst, lnk_en, pwr, start, tie, ts_n, alt_n, sysref, req_n, ref_on, edge_p, cgs, ilas, up;
    encoding_type enc;
    logic [1:0]   sel;
    logic [7:0]   lanes, chk;
    logic [63:0]  ch;
    logic [3:0]   st;
    int           miscompares, total_checks;
    assign st = {edge_p, up, ilas, cgs};

    serial_link_sync_request_control uut (.i_core_clk(clk), .i_sys_rst(rst), .i_encoding(enc), .i_sync_sel(sel),
        .i_lane_enable(lanes), .i_link_enable(lnk_en), .i_sysref_receiver_power_enable(pwr),
        .i_single_ended_link_request_n(tie ? 1'b0 : req_n),
        .i_timestamp_diff_input(ts_n), .i_alternate_link_request_n(alt_n), .i_sysref(sysref),
        .o_lane_char(ch), .o_lane_char_is_k(chk), .o_sysref_receiver_on(ref_on), .o_sysref_edge(edge_p),
        .o_in_cgs(cgs), .o_in_ilas(ilas), .o_link_up(up));
    link_rx_model rx (.i_core_clk(clk), .i_start(start), .i_hold(4'h2), .i_in_cgs(cgs), .o_request_n(req_n));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tick;
        @(posedge clk);
        #10;
    endtask : tick
    task automatic wrap_up;
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_on(input int k);
        int n;
        n = 0;
        while (st[k] !== 1'b1) begin
            tick;
            n++;
            if (n > 40) begin
                miscompares++;
                $display("[FAIL] %0t state %0d never reached", $time, k);
                wrap_up;
            end
        end
    endtask : wait_on
    task automatic go_idle;
        lnk_en = 1'b0;
        tick;
        lnk_en = 1'b1;
    endtask : go_idle
    task automatic pulse_ref;
        sysref = 1'b1;
        repeat (4) tick;
        sysref = 1'b0;
    endtask : pulse_ref
    task automatic s_se_bringup;
        lanes = 8'h7f;
        start = 1'b1;
        tick;
        start = 1'b0;
        wait_on(0);
        check(ch[7:0], COMMA_K28_5);
        check({7'h0, chk[0]}, 8'h01);
        check({7'h0, chk[7]}, 8'h00);
        wait_on(1);
        check(ch[7:0], ILAS_START_K28_0);
        repeat (8) tick;
        check({7'h0, up}, 8'h00);
        pulse_ref;
        wait_on(3);
        tick;
        check({7'h0, edge_p}, 8'h00);
        repeat (ILAS_LEN_DEFAULT - 2) tick;
        check({7'h0, up}, 8'h00);
        tick;
        check({7'h0, up}, 8'h01);
        check(ch[7:0], IDLE_DATA);
        start = 1'b1;
        tick;
        start = 1'b0;
        wait_on(0);
    endtask : s_se_bringup
    task automatic s_other(input logic [1:0] s);
        go_idle;
        sel = s;
        tie = 1'b1;
        repeat (10) tick;
        check({7'h0, cgs}, 8'h00);
        ts_n = (s != SYNC_SEL_TS);
        alt_n = (s != SYNC_SEL_ALT);
        wait_on(0);
        ts_n = 1'b1;
        alt_n = 1'b1;
        wait_on(1);
    endtask : s_other
    task automatic s_wide;
        go_idle;
        enc = ENC_64B66B;
        sel = SYNC_SEL_SE;
        repeat (10) tick;
        check({4'h0, st}, 8'h04);
        enc = ENC_8B10B;
        tie = 1'b0;
    endtask : s_wide
    task automatic s_ref_off;
        go_idle;
        pwr = 1'b0;
        start = 1'b1;
        tick;
        start = 1'b0;
        wait_on(1);
        pulse_ref;
        repeat (12) tick;
        check({6'h0, ref_on, up}, 8'h00);
        pwr = 1'b1;
    endtask : s_ref_off

    initial begin
        {rst, lnk_en, pwr, ts_n, alt_n} = 5'h1f;
        {start, tie, sysref, sel} = 5'h0;
        enc = ENC_8B10B;
        lanes = 8'hff;
        miscompares = 0;
        total_checks = 0;
        repeat (8) tick;
        rst = 1'b0;
        repeat (6) tick;
        s_se_bringup;
        s_other(SYNC_SEL_TS);
        s_other(SYNC_SEL_ALT);
        s_wide;
        s_ref_off;
        wrap_up;
    end
endmodule : serial_link_sync_request_control_tb
